// [hdl/isl_regs.vh]
// Constants for the two-wire serial slave engine.
// Assumes a 125 MHz system clock and the link clock at most 1/8 of it.
`ifndef ISL_REGS_VH
`define ISL_REGS_VH

// Bit positions inside the slave mode select field.
`define ISL_MODE_10BIT      0
`define ISL_MODE_STARTSTOP  1

// High address byte prefix for 10-bit addressing.
`define ISL_HI10_PREFIX     5'h1E

// Bit count within a byte: eight data bits, then the acknowledge bit.
`define ISL_BITS_DATA       4'h8
`define ISL_BITS_ACK        4'h9

// Pin filter: a new level is taken after this many equal samples.
`define ISL_FILT_LEN        3

// Receive buffer shape.
`define ISL_FIFO_WIDTH      8
`define ISL_FIFO_DEPTH      16
`define ISL_FIFO_AW         4

// Reset value of the own address register.
`define ISL_ADDR_RESET      8'h00

`endif

// [hdl/isl_slave.v]
// Two-wire serial slave engine with a receive buffer.
// Assumes an external bus master, pull-ups on both lines and a link clock
// well below the system clock; software controls are same-clock signals.
`timescale 1ns/10ps
`include "isl_regs.vh"

module isl_fifo #(
  parameter WIDTH = `ISL_FIFO_WIDTH,
  parameter DEPTH = `ISL_FIFO_DEPTH,
  parameter AW    = `ISL_FIFO_AW
) (
  // Clock and reset.
  input  wire             i_clk,
  input  wire             i_rst,
  // Fill side.
  input  wire             i_wr_valid,
  output wire             o_wr_ready,
  input  wire [WIDTH-1:0] i_wr_data,
  // Drain side.
  output wire             o_rd_valid,
  input  wire             i_rd_ready,
  output wire [WIDTH-1:0] o_rd_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_wr;
  wire            do_rd;

  // The count is widened to the parameter's width, so nothing is cut.
  assign o_wr_ready = (count_reg != DEPTH);
  assign o_rd_valid = (count_reg != {(AW+1){1'b0}});
  assign o_rd_data  = mem_reg[rd_ptr_reg];
  assign do_wr      = i_wr_valid & o_wr_ready;
  assign do_rd      = i_rd_ready & o_rd_valid;

  always @(posedge i_clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= i_wr_data;
    end
    if (i_rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // isl_fifo

module isl_slave (
  // Clock and reset.
  input  wire       i_clk,
  input  wire       i_rst,
  // Bus pins, open drain: enable high pulls the line low.
  input  wire       i_scl,
  output reg        o_scl_out,
  output reg        o_scl_oe,
  input  wire       i_sda,
  output reg        o_sda_out,
  output reg        o_sda_oe,
  // Configuration.
  input  wire [1:0] i_slave_mode_select,
  input  wire       i_stretch_enable,
  input  wire       i_address_hold_enable,
  input  wire       i_data_hold_enable,
  input  wire       i_buffer_overwrite_enable,
  input  wire       i_slave_collision_detect_enable,
  input  wire       i_ack_reply_value,
  // Software strobes.
  input  wire       i_own_address_wr,
  input  wire [7:0] i_own_address_data,
  input  wire       i_clock_release_set,
  input  wire       i_event_clear,
  input  wire       i_overflow_clear,
  input  wire       i_collision_clear,
  input  wire       i_tx_load,
  input  wire [7:0] i_tx_data,
  // Received byte stream.
  output wire       o_rx_valid,
  input  wire       i_rx_ready,
  output wire [7:0] o_rx_data,
  // Status.
  output reg  [7:0] o_own_address_reg,
  output reg        o_serial_event_flag,
  output reg        o_update_address_flag,
  output reg        o_receive_overflow_flag,
  output reg        o_bus_collision_flag,
  output reg        o_clock_release_bit,
  output reg        o_ack_phase_flag,
  output reg        o_master_ack_result,
  output reg        o_read_write_status,
  output reg        o_start_seen,
  output reg        o_stop_seen,
  output reg        o_buffer_full_flag
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_RXD  = 3'h2;
  localparam [2:0] ST_TXD  = 3'h3;

  function f_hi10;
    input [7:0] rx;
    input [7:0] own;
    begin
      f_hi10 = (rx[7:3] == `ISL_HI10_PREFIX) && (rx[2:1] == own[2:1]);
    end
  endfunction

  wire [1:0] line_lvl;
  wire [1:0] line_dly;
  reg  [2:0] st_reg;
  reg  [3:0] cnt_reg;
  reg  [7:0] sh_reg;
  reg  [7:0] tx_reg;
  reg        lo_phase_reg;
  reg        matched10_reg;
  reg        hold_reg;
  reg        ack_reg;
  reg        lo_hit_reg;
  reg        push_reg;
  reg  [7:0] push_data_reg;
  wire       fifo_ready;
  wire       scl_f;
  wire       sda_f;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       mode10;
  wire       hit7;
  wire       hit_lo;
  wire       is_addr;
  wire       hold_mode;
  wire       busy;
  wire       hold_req;
  genvar     g;

  // Index 0 is the clock line, index 1 the data line.
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      wire       pin_in;
      reg  [1:0] sync_reg;
      reg  [1:0] filt_reg;
      reg        line_reg;
      reg        line_d_reg;
      assign pin_in      = (g == 0) ? i_scl : i_sda;
      assign line_lvl[g] = line_reg;
      assign line_dly[g] = line_d_reg;
      always @(posedge i_clk) begin
        if (i_rst) begin
          sync_reg   <= 2'h3;
          filt_reg   <= 2'h3;
          line_reg   <= 1'b1;
          line_d_reg <= 1'b1;
        end else begin
          sync_reg <= {sync_reg[0], pin_in};
          filt_reg <= {filt_reg[0], sync_reg[1]};
          // Glitches shorter than the filter span never reach the decoder.
          if (filt_reg == {2{sync_reg[1]}}) begin
            line_reg <= sync_reg[1];
          end
          line_d_reg <= line_reg;
        end
      end
    end
  endgenerate

  assign scl_f     = line_lvl[0];
  assign sda_f     = line_lvl[1];
  assign scl_rise  = scl_f & ~line_dly[0];
  assign scl_fall  = ~scl_f & line_dly[0];
  assign start_det = scl_f & line_dly[0] & ~sda_f & line_dly[1];
  assign stop_det  = scl_f & line_dly[0] & sda_f & ~line_dly[1];
  assign mode10    = i_slave_mode_select[`ISL_MODE_10BIT];
  assign hit7      = (sh_reg[7:1] == o_own_address_reg[7:1]);
  assign hit_lo    = (sh_reg == o_own_address_reg);
  assign is_addr   = (st_reg == ST_ADDR);
  assign hold_mode = is_addr ? i_address_hold_enable : i_data_hold_enable;
  assign busy      = !i_buffer_overwrite_enable &
                     (!fifo_ready | o_receive_overflow_flag);
  assign hold_req  = (!o_clock_release_bit && st_reg != ST_IDLE) ||
                     o_update_address_flag;

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_buffer_full_flag <= 1'b0;
    end else begin
      o_buffer_full_flag <= !fifo_ready;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      st_reg                  <= ST_IDLE;
      cnt_reg                 <= 4'h0;
      sh_reg                  <= 8'h00;
      tx_reg                  <= 8'h00;
      lo_phase_reg            <= 1'b0;
      matched10_reg           <= 1'b0;
      hold_reg                <= 1'b0;
      ack_reg                 <= 1'b0;
      lo_hit_reg              <= 1'b0;
      push_reg                <= 1'b0;
      push_data_reg           <= 8'h00;
      o_scl_out               <= 1'b0;
      o_scl_oe                <= 1'b0;
      o_sda_out               <= 1'b0;
      o_sda_oe                <= 1'b0;
      o_own_address_reg       <= `ISL_ADDR_RESET;
      o_serial_event_flag     <= 1'b0;
      o_update_address_flag   <= 1'b0;
      o_receive_overflow_flag <= 1'b0;
      o_bus_collision_flag    <= 1'b0;
      o_clock_release_bit     <= 1'b1;
      o_ack_phase_flag        <= 1'b0;
      o_master_ack_result     <= 1'b0;
      o_read_write_status     <= 1'b0;
      o_start_seen            <= 1'b0;
      o_stop_seen             <= 1'b0;
    end else begin
      // Software clears come first so that a hardware set in the same
      // cycle, written further down, takes priority.
      push_reg <= 1'b0;
      if (i_event_clear) begin
        o_serial_event_flag <= 1'b0;
      end
      if (i_overflow_clear) begin
        o_receive_overflow_flag <= 1'b0;
      end
      if (i_collision_clear) begin
        o_bus_collision_flag <= 1'b0;
      end
      if (i_clock_release_set) begin
        o_clock_release_bit <= 1'b1;
      end
      if (i_own_address_wr) begin
        o_own_address_reg     <= i_own_address_data;
        o_update_address_flag <= 1'b0;
      end
      if (i_tx_load) begin
        tx_reg <= i_tx_data;
      end
      // The line is grabbed only once it is already low.
      if (hold_req) begin
        if (!scl_f) begin
          o_scl_oe <= 1'b1;
        end
      end else begin
        o_scl_oe <= 1'b0;
      end
      // Software picks the reply while the hold is in force.
      if (hold_reg && cnt_reg == `ISL_BITS_DATA) begin
        ack_reg  <= !i_ack_reply_value;
        o_sda_oe <= !i_ack_reply_value;
      end
      if (st_reg == ST_TXD && !scl_f && cnt_reg < `ISL_BITS_DATA) begin
        o_sda_oe <= !tx_reg[3'h7 - cnt_reg[2:0]];
      end

      if (start_det) begin
        st_reg           <= ST_ADDR;
        cnt_reg          <= 4'h0;
        lo_phase_reg     <= 1'b0;
        hold_reg         <= 1'b0;
        o_sda_oe         <= 1'b0;
        o_ack_phase_flag <= 1'b0;
        o_start_seen     <= 1'b1;
        o_stop_seen      <= 1'b0;
        if (i_slave_mode_select[`ISL_MODE_STARTSTOP]) begin
          o_serial_event_flag <= 1'b1;
        end
      end else if (stop_det) begin
        st_reg           <= ST_IDLE;
        matched10_reg    <= 1'b0;
        hold_reg         <= 1'b0;
        o_sda_oe         <= 1'b0;
        o_ack_phase_flag <= 1'b0;
        o_start_seen     <= 1'b0;
        o_stop_seen      <= 1'b1;
        if (i_slave_mode_select[`ISL_MODE_STARTSTOP]) begin
          o_serial_event_flag <= 1'b1;
        end
      end else if (scl_rise && st_reg != ST_IDLE) begin
        if (cnt_reg < `ISL_BITS_DATA) begin
          sh_reg  <= {sh_reg[6:0], sda_f};
          cnt_reg <= cnt_reg + 4'h1;
          // A released line seen low means someone else is driving it.
          if (st_reg == ST_TXD && !o_sda_oe && !sda_f) begin
            st_reg   <= ST_IDLE;
            o_sda_oe <= 1'b0;
            if (i_slave_collision_detect_enable) begin
              o_bus_collision_flag <= 1'b1;
            end
          end
        end else if (cnt_reg == `ISL_BITS_DATA) begin
          cnt_reg <= `ISL_BITS_ACK;
          if (st_reg == ST_TXD) begin
            o_master_ack_result <= sda_f;
          end
        end
      end else if (scl_fall && st_reg != ST_IDLE) begin
        if (cnt_reg == `ISL_BITS_DATA && st_reg == ST_TXD) begin
          // The master owns the data line for its acknowledge bit.
          o_sda_oe <= 1'b0;
        end else if (cnt_reg == `ISL_BITS_DATA) begin
          // Eighth falling edge of a received byte.
          if (is_addr && mode10 && lo_phase_reg) begin
            lo_hit_reg <= hit_lo;
            ack_reg    <= hit_lo & !busy;
            o_sda_oe   <= hit_lo & !busy;
            if (hit_lo) begin
              push_reg      <= 1'b1;
              push_data_reg <= sh_reg;
            end
          end else if (is_addr && (mode10 ? !(f_hi10(sh_reg, o_own_address_reg) &&
                       (!sh_reg[0] || matched10_reg)) : !hit7)) begin
            st_reg <= ST_IDLE;
            if (mode10) begin
              matched10_reg <= 1'b0;
            end
          end else begin
            if (fifo_ready) begin
              push_reg      <= 1'b1;
              push_data_reg <= sh_reg;
            end else if (!is_addr) begin
              o_receive_overflow_flag <= 1'b1;
            end
            if (is_addr) begin
              o_read_write_status <= sh_reg[0];
              if (mode10 && !sh_reg[0]) begin
                matched10_reg <= 1'b0;
              end
            end
            if (hold_mode) begin
              hold_reg            <= 1'b1;
              o_clock_release_bit <= 1'b0;
              o_serial_event_flag <= 1'b1;
              o_ack_phase_flag    <= 1'b1;
            end else begin
              ack_reg  <= !busy;
              o_sda_oe <= !busy;
            end
          end
        end else if (cnt_reg == `ISL_BITS_ACK) begin
          // Ninth falling edge: the acknowledge bit is over.
          cnt_reg          <= 4'h0;
          hold_reg         <= 1'b0;
          o_sda_oe         <= 1'b0;
          o_ack_phase_flag <= 1'b0;
          if (st_reg == ST_TXD) begin
            o_serial_event_flag <= 1'b1;
            if (o_master_ack_result) begin
              st_reg <= ST_IDLE;
            end else begin
              o_clock_release_bit <= 1'b0;
            end
          end else if (is_addr && mode10 && lo_phase_reg) begin
            o_serial_event_flag   <= 1'b1;
            o_update_address_flag <= 1'b1;
            matched10_reg         <= lo_hit_reg & ack_reg;
            st_reg                <= (lo_hit_reg & ack_reg) ? ST_RXD : ST_IDLE;
            if (lo_hit_reg && ack_reg && i_stretch_enable) begin
              o_clock_release_bit <= 1'b0;
            end
          end else if (!ack_reg) begin
            st_reg <= ST_IDLE;
          end else begin
            o_serial_event_flag <= 1'b1;
            if (is_addr && o_read_write_status) begin
              st_reg              <= ST_TXD;
              o_clock_release_bit <= 1'b0;
            end else if (is_addr && mode10) begin
              lo_phase_reg          <= 1'b1;
              o_update_address_flag <= 1'b1;
            end else begin
              st_reg <= ST_RXD;
              if (i_stretch_enable) begin
                o_clock_release_bit <= 1'b0;
              end
            end
          end
        end
      end
    end
  end

  isl_fifo #(
    .WIDTH (`ISL_FIFO_WIDTH),
    .DEPTH (`ISL_FIFO_DEPTH),
    .AW    (`ISL_FIFO_AW)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_wr_valid (push_reg),
    .o_wr_ready (fifo_ready),
    .i_wr_data  (push_data_reg),
    .o_rd_valid (o_rx_valid),
    .i_rd_ready (i_rx_ready),
    .o_rd_data  (o_rx_data)
  );
endmodule // isl_slave

// [tb/isl_master_bfm.sv]
// Bus master model for the two-wire slave: start, stop and byte transfers.
// Lines are open drain; the bench resolves them with the slave's enables.
`timescale 1ns/10ps
module isl_master_bfm (
  // Resolved line levels.
  input  wire logic i_scl,
  input  wire logic i_sda,
  // High pulls the line low.
  output logic      o_scl_low,
  output logic      o_sda_low
);
  localparam int Q = 32;

  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  // Releasing the clock waits on the line, so a slave stretch stalls us.
  task automatic rise;
    o_scl_low = 1'b0;
    wait (i_scl);
    #Q;
  endtask

  task automatic bit_io(input logic b, output logic r);
    #Q o_sda_low = !b;
    #Q rise;
    r = i_sda;
    #Q o_scl_low = 1'b1;
  endtask

  task automatic start;
    #Q o_sda_low = 1'b0;
    #Q rise;
    o_sda_low = 1'b1;
    #Q o_scl_low = 1'b1;
  endtask

  task automatic stop;
    #Q o_sda_low = 1'b1;
    #Q rise;
    o_sda_low = 1'b0;
    #(2*Q);
  endtask

  task automatic xfer(input logic [7:0] t, input logic ai, output logic [7:0] r,
                      output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(t[i], r[i]);
    bit_io(ai, ao);
  endtask
endmodule // isl_master_bfm

// [tb/isl_slave_chk.sv]
// Checker for the two-wire serial slave engine: pin and status relations.
// Bound to isl_slave by the bench; every signal but the i_scl pin is in the system clock domain.
`timescale 1ns/10ps
module isl_slave_chk (
  // Clock and reset.
  input wire logic       i_clk,
  input wire logic       i_rst,
  // Pins.
  input wire logic       i_scl,
  input wire logic       o_scl_out,
  input wire logic       o_scl_oe,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  // Controls.
  input wire logic       i_address_hold_enable,
  input wire logic       i_data_hold_enable,
  input wire logic       i_slave_collision_detect_enable,
  input wire logic       i_own_address_wr,
  input wire logic [7:0] i_own_address_data,
  // Status.
  input wire logic [7:0] o_own_address_reg,
  input wire logic       o_update_address_flag,
  input wire logic       o_bus_collision_flag,
  input wire logic       o_clock_release_bit,
  input wire logic       o_ack_phase_flag,
  input wire logic       o_master_ack_result,
  input wire logic       o_rx_valid,
  input wire logic       o_buffer_full_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_open_drain;
    o_scl_out == 1'b0 && o_sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin output level is not low");

  // Grabbing the clock while it is high would cut the master's high time.
  property p_hold_after_low;
    $rose(o_scl_oe) |-> !$past(i_scl);
  endproperty
  a_hold_after_low: assert property (p_hold_after_low)
    else $error("clock pulled low while line was high");

  property p_release;
    o_scl_oe && o_clock_release_bit && !o_update_address_flag |-> ##[1:3] !o_scl_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("clock still held after release");

  property p_addr_write;
    i_own_address_wr |=> !o_update_address_flag && o_own_address_reg == $past(i_own_address_data);
  endproperty
  a_addr_write: assert property (p_addr_write)
    else $error("own address write not taken");

  property p_ack_phase;
    o_ack_phase_flag |-> i_address_hold_enable || i_data_hold_enable;
  endproperty
  a_ack_phase: assert property (p_ack_phase)
    else $error("ack phase flag outside hold modes");

  property p_sda_stable;
    i_scl [*8] |-> $stable(o_sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("data line changed while clock high");

  property p_full;
    o_buffer_full_flag |-> o_rx_valid;
  endproperty
  a_full: assert property (p_full)
    else $error("full flag with empty buffer");

  property p_collide;
    $rose(o_bus_collision_flag) |-> i_slave_collision_detect_enable;
  endproperty
  a_collide: assert property (p_collide)
    else $error("collision flag while detection disabled");

  property p_mack;
    $changed(o_master_ack_result) |-> i_scl;
  endproperty
  a_mack: assert property (p_mack)
    else $error("master ack result changed while clock low");
endmodule // isl_slave_chk

// [tb/isl_slave_tb.sv]
// Self-checking bench for the two-wire serial slave engine.
// A master model drives the bus; software strobes are pulsed by tasks.
`timescale 1ns/10ps
module isl_slave_tb;
  logic       i_clk, i_rst, i_rx_ready, m_scl, m_sda, a;
  logic [7:0] cf, sd, r;
  logic [5:0] sw;
  int         fails, n_compared, n;
  wire        o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_rx_valid;
  wire        o_serial_event_flag, o_update_address_flag, o_receive_overflow_flag;
  wire        o_bus_collision_flag, o_clock_release_bit, o_ack_phase_flag;
  wire        o_master_ack_result, o_read_write_status, o_start_seen, o_stop_seen;
  wire        o_buffer_full_flag;
  wire [7:0]  o_rx_data, o_own_address_reg;
  wire        i_scl = !(m_scl || o_scl_oe);
  wire        i_sda = !(m_sda || o_sda_oe);
  wire [1:0]  i_slave_mode_select = cf[7:6];
  wire        i_stretch_enable = cf[5], i_address_hold_enable = cf[4];
  wire        i_data_hold_enable = cf[3], i_buffer_overwrite_enable = cf[2];
  wire        i_slave_collision_detect_enable = cf[1], i_ack_reply_value = cf[0];
  wire        i_clock_release_set = sw[0], i_event_clear = sw[1], i_overflow_clear = sw[2];
  wire        i_collision_clear = sw[3], i_tx_load = sw[4], i_own_address_wr = sw[5];
  wire [7:0]  i_tx_data = sd, i_own_address_data = sd;

  isl_slave u_dut (.*);
  isl_master_bfm u_m (.i_scl(i_scl), .i_sda(i_sda), .o_scl_low(m_scl), .o_sda_low(m_sda));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic settle;
    cyc(12);
    @(negedge i_clk);
  endtask
  task automatic cfg(input logic [7:0] c);
    @(posedge i_clk);
    cf <= c;
  endtask
  task automatic strobe(input logic [5:0] w, input logic [7:0] d);
    @(posedge i_clk);
    sw <= w;
    sd <= d;
    @(posedge i_clk);
    sw <= 6'h00;
    @(negedge i_clk);
  endtask
  task automatic xf(input logic [7:0] t, input logic ai);
    u_m.xfer(t, ai, r, a);
    settle;
  endtask
  task automatic held;
    n = 0;
    while (o_clock_release_bit !== 1'b0 && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    settle;
  endtask
  task automatic serve(input logic ld, input logic [7:0] d);
    held;
    chk(o_scl_oe, 1'b1);
    if (ld) strobe(6'h10, d);
    strobe(6'h01, d);
  endtask
  task automatic pop(input logic [7:0] e);
    chk({o_rx_valid, o_rx_data}, {1'b1, e});
    @(posedge i_clk);
    i_rx_ready <= 1'b1;
    @(posedge i_clk);
    i_rx_ready <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic flush;
    @(posedge i_clk);
    i_rx_ready <= 1'b1;
    cyc(20);
    i_rx_ready <= 1'b0;
    settle;
    chk(o_rx_valid, 1'b0);
  endtask

  task automatic t_basic;
    cfg(8'h80);
    strobe(6'h20, 8'h84);
    u_m.start;
    settle;
    chk({o_start_seen, o_serial_event_flag}, 2'b11);
    strobe(6'h02, 8'h00);
    xf(8'h84, 1'b1);
    chk({a, o_read_write_status, o_serial_event_flag}, 3'b001);
    strobe(6'h02, 8'h00);
    xf(8'h5A, 1'b1);
    chk({a, o_serial_event_flag}, 2'b01);
    u_m.stop;
    settle;
    chk({o_stop_seen, o_start_seen, o_serial_event_flag}, 3'b101);
    pop(8'h84);
    pop(8'h5A);
    cfg(8'h00);
    strobe(6'h02, 8'h00);
    u_m.start;
    xf(8'h86, 1'b1);
    chk({a, o_serial_event_flag, o_rx_valid}, 3'b100);
    u_m.stop;
    settle;
    $display("basic write test done");
  endtask

  task automatic t_read;
    cfg(8'h20);
    u_m.start;
    xf(8'h84, 1'b1);
    serve(1'b0, 8'h00);
    xf(8'h11, 1'b1);
    serve(1'b0, 8'h00);
    u_m.stop;
    settle;
    pop(8'h84);
    pop(8'h11);
    u_m.start;
    xf(8'h85, 1'b1);
    chk({a, o_read_write_status}, 2'b01);
    serve(1'b1, 8'hA5);
    xf(8'hFF, 1'b0);
    chk({r, o_master_ack_result}, {8'hA5, 1'b0});
    strobe(6'h02, 8'h00);
    serve(1'b1, 8'h3C);
    xf(8'hFF, 1'b1);
    chk({r, o_master_ack_result, o_serial_event_flag, o_scl_oe}, {8'h3C, 3'b110});
    u_m.stop;
    settle;
    pop(8'h85);
    cfg(8'h22);
    u_m.start;
    xf(8'h85, 1'b1);
    serve(1'b1, 8'hFF);
    xf(8'h00, 1'b1);
    chk({o_bus_collision_flag, o_scl_oe, o_sda_oe}, 3'b100);
    u_m.stop;
    strobe(6'h08, 8'h00);
    pop(8'h85);
    $display("stretch and read test done");
  endtask

  task automatic t_fifo;
    cfg(8'h00);
    u_m.start;
    xf(8'h84, 1'b1);
    for (int i = 0; i < 16; i++) xf(i[7:0], 1'b1);
    chk({o_buffer_full_flag, o_receive_overflow_flag}, 2'b11);
    u_m.stop;
    u_m.start;
    xf(8'h84, 1'b1);
    chk(a, 1'b1);
    u_m.stop;
    settle;
    pop(8'h84);
    for (int i = 0; i < 15; i++) pop(i[7:0]);
    chk(o_rx_valid, 1'b0);
    cfg(8'h04);
    u_m.start;
    xf(8'h84, 1'b1);
    chk(a, 1'b0);
    u_m.stop;
    settle;
    pop(8'h84);
    strobe(6'h04, 8'h00);
    chk(o_receive_overflow_flag, 1'b0);
    $display("buffer test done");
  endtask

  task automatic t_ten;
    cfg(8'h40);
    strobe(6'h20, 8'hF2);
    u_m.start;
    xf(8'hF2, 1'b1);
    chk({a, o_update_address_flag, o_scl_oe}, 3'b011);
    strobe(6'h22, 8'h34);
    chk(o_update_address_flag, 1'b0);
    xf(8'h34, 1'b1);
    chk({a, o_update_address_flag, o_serial_event_flag}, 3'b011);
    strobe(6'h20, 8'hF2);
    xf(8'h77, 1'b1);
    chk(a, 1'b0);
    u_m.start;
    xf(8'hF3, 1'b1);
    chk({a, o_read_write_status}, 2'b01);
    serve(1'b1, 8'h9C);
    xf(8'hFF, 1'b1);
    chk(r, 8'h9C);
    u_m.stop;
    flush;
    $display("ten bit test done");
  endtask

  task automatic t_hold;
    cfg(8'h11);
    strobe(6'h20, 8'h84);
    u_m.start;
    settle;
    fork
      xf(8'h84, 1'b1);
      begin
        held;
        chk({o_ack_phase_flag, o_serial_event_flag}, 2'b11);
        strobe(6'h03, 8'h00);
      end
    join
    chk({a, o_serial_event_flag}, 2'b10);
    u_m.stop;
    flush;
    $display("hold test done");
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    cyc(40000);
    fails++;
    tally_and_finish;
  end
  initial begin
    i_rst = 1'b1;
    i_rx_ready = 1'b0;
    cf = 8'h00;
    sw = 6'h00;
    sd = 8'h00;
    fails = 0;
    n_compared = 0;
    cyc(12);
    i_rst <= 1'b0;
    settle;
    chk({o_clock_release_bit, o_own_address_reg, o_rx_valid}, {1'b1, 8'h00, 1'b0});
    t_basic;
    t_read;
    t_fifo;
    t_ten;
    t_hold;
    tally_and_finish;
  end
endmodule // isl_slave_tb

bind isl_slave isl_slave_chk u_chk (.*);
